// *** hw/pld_pkg.sv ***
package pld_pkg;

  // ************************************************************
  // Array geometry
  // ************************************************************
  localparam int NUM_CELLS    = 8;
  localparam int NUM_TERMS    = 8;
  localparam int NUM_INPUTS   = 8;
  localparam int ARRAY_WIDTH  = 16;
  localparam int TERM_WIDTH   = 2 * ARRAY_WIDTH;
  localparam int SIG_BYTES    = 8;
  localparam int SIG_BITS     = 64;
  localparam int OE_TERM      = 0;
  localparam int CENTRE_LO    = 3;
  localparam int CENTRE_HI    = 4;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS                = 100;
  localparam int POWER_UP_CLEAR_INTERVAL_NS   = 1000;
  localparam int POWER_UP_CLEAR_TYP_NS        = 600;
  localparam int POWER_UP_CLEAR_CYCLES        =
    (POWER_UP_CLEAR_INTERVAL_NS / CLK_PERIOD_NS < 1) ? 1 :
    POWER_UP_CLEAR_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int CLR_CNT_W                    = 4;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [NUM_CELLS-1:0] CELL_RST   = 8'h00;
  localparam logic                 SECURE_RST = 1'b0;

  // ************************************************************
  // Modes and cell kinds
  // ************************************************************
  typedef enum logic [2:0] {
    MODE_REGISTERED = 3'b001,
    MODE_COMPLEX    = 3'b010,
    MODE_SIMPLE     = 3'b100
  } mode_t;

  typedef enum logic [1:0] {
    CELL_REG  = 2'h0,
    CELL_BIDI = 2'h1,
    CELL_OUT  = 2'h2,
    CELL_IN   = 2'h3
  } cell_kind_t;

  typedef enum logic [1:0] {
    ST_CLEAR = 2'b01,
    ST_RUN   = 2'b10
  } pwr_state_t;

  // ************************************************************
  // Programmer request and answer
  // ************************************************************
  typedef struct packed {
    logic                 preload;
    logic [NUM_CELLS-1:0] preload_data;
    logic                 verify;
    logic [2:0]           sig_index;
    logic                 sig_read;
    logic                 secure;
  } prog_req_t;

  typedef struct packed {
    logic       ack;
    logic       refused;
    logic [7:0] data;
  } prog_rsp_t;

endpackage : pld_pkg

// *** hw/pld_cell.sv ***
`timescale 1ns/1ps
module pld_cell
  import pld_pkg::*;
(
  input  wire logic [ARRAY_WIDTH-1:0]             array_in,
  input  wire logic [NUM_TERMS-1:0][TERM_WIDTH-1:0] term_sel,
  input  wire logic [NUM_TERMS-1:0]               term_used,
  input  wire mode_t                              mode,
  input  wire cell_kind_t                         kind,
  output wire logic                               sum,
  output wire logic                               oe_term
);
  logic [NUM_TERMS-1:0] prod;
  logic [TERM_WIDTH-1:0] lits;
  wire                   uses_oe;

  assign lits = {~array_in, array_in};

  genvar t;
  generate
    for (t = 0; t < NUM_TERMS; t++) begin : g_term
      // AND of selected true/complement literals; unused terms contribute zero
      assign prod[t] = term_used[t] & (&(lits | ~term_sel[t]));
    end
  endgenerate

  // Complex mode and combinational cells of registered mode give term 0 to enable
  assign uses_oe = (mode == MODE_COMPLEX) ||
                   ((mode == MODE_REGISTERED) && (kind != CELL_REG));
  assign sum     = uses_oe ? |prod[NUM_TERMS-1:1] : |prod;
  assign oe_term = uses_oe ? prod[OE_TERM] : 1'b1;

endmodule : pld_cell

// *** hw/pld_core.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Clear all registers low after power-up
// - Registered outputs show inverted register
// - Programmer preloads each register high/low
// - Security blocks verify and preload
// - 64-bit signature always readable
// - Keepers hold undriven pins' last level
// - Cell: registered, bidir, output, input
// - One of three global modes
// - Unused product terms disabled
// - Registered: common clock, OE pin, eight terms for register cells
// - Complex: seven terms plus enable term
// - Simple: eight terms, centre cells enabled
// - Dedicated input keeps driver disabled, except centre cells in simple mode
module pld_core
  import pld_pkg::*;
(
  input  wire logic                                              CLOCK,
  input  wire logic                                              RESET,
  input  wire logic                                              CLK_EN,
  input  wire logic                                              OE_N,
  input  wire logic [NUM_INPUTS-1:0]                             IN_PINS,
  input  wire logic [NUM_CELLS-1:0]                              IO_IN,
  input  wire logic [NUM_CELLS-1:0]                              IO_EXT_DRIVE,
  output logic      [NUM_CELLS-1:0]                              IO_OUT,
  output logic      [NUM_CELLS-1:0]                              IO_OE,
  input  wire mode_t                                             MODE,
  input  wire cell_kind_t [NUM_CELLS-1:0]                        CELL_KIND,
  input  wire logic [NUM_CELLS-1:0][NUM_TERMS-1:0][TERM_WIDTH-1:0] TERM_SEL,
  input  wire logic [NUM_CELLS-1:0][NUM_TERMS-1:0]               TERM_USED,
  input  wire logic [SIG_BITS-1:0]                               SIGNATURE,
  input  wire logic [NUM_CELLS-1:0]                              PATTERN_WORD,
  input  wire prog_req_t                                         PROG_REQ,
  output prog_rsp_t                                              PROG_RSP,
  output logic                                                   SECURED,
  output logic                                                   READY
);

  // ************************************************************
  // Power-up clear sequencer
  // ************************************************************
  pwr_state_t           state_r;
  pwr_state_t           state_nxt;
  logic [CLR_CNT_W-1:0] clr_cnt_r;
  wire                  clr_done;
  wire                  clearing;

  assign clr_done  = (clr_cnt_r == CLR_CNT_W'(POWER_UP_CLEAR_CYCLES - 1));
  assign clearing  = (state_r == ST_CLEAR);

  always_comb begin
    case (state_r)
      ST_CLEAR: state_nxt = clr_done ? ST_RUN : ST_CLEAR;
      ST_RUN:   state_nxt = ST_RUN;
      default:  state_nxt = ST_CLEAR;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state_r   <= ST_CLEAR;
      clr_cnt_r <= '0;
    end else begin
      state_r   <= state_nxt;
      clr_cnt_r <= clearing ? clr_cnt_r + 1'b1 : clr_cnt_r;
    end
  end

  // ************************************************************
  // Pin keepers and array inputs
  // ************************************************************
  logic [NUM_CELLS-1:0]   keep_r;
  logic [NUM_CELLS-1:0]   pin_level;
  logic [NUM_CELLS-1:0]   feedback;
  logic [ARRAY_WIDTH-1:0] array_in;
  logic [NUM_CELLS-1:0]   cell_reg_r;
  logic [NUM_CELLS-1:0]   sum;
  logic [NUM_CELLS-1:0]   oe_term;
  logic [NUM_CELLS-1:0]   oe_nxt;
  logic [NUM_CELLS-1:0]   out_nxt;
  logic [NUM_CELLS-1:0]   reg_nxt;

  // Pin shows driver's value, else our own, else the kept level
  genvar c;
  generate
    for (c = 0; c < NUM_CELLS; c++) begin : g_cell
      assign pin_level[c] = IO_EXT_DRIVE[c] ? IO_IN[c] :
                            IO_OE[c] ? IO_OUT[c] : keep_r[c];
      assign feedback[c]  = (CELL_KIND[c] == CELL_REG) ? cell_reg_r[c] : pin_level[c];

      pld_cell u_cell (
        .array_in (array_in),
        .term_sel (TERM_SEL[c]),
        .term_used(TERM_USED[c]),
        .mode     (MODE),
        .kind     (CELL_KIND[c]),
        .sum      (sum[c]),
        .oe_term  (oe_term[c])
      );

      // Output driver enable per mode and cell kind
      assign oe_nxt[c] =
        ((MODE == MODE_SIMPLE) && (c == CENTRE_LO || c == CENTRE_HI)) ? 1'b1 :
        (CELL_KIND[c] == CELL_IN)  ? 1'b0 :
        (MODE == MODE_SIMPLE)      ? 1'b1 :
        ((MODE == MODE_REGISTERED) && (CELL_KIND[c] == CELL_REG)) ? ~OE_N :
        oe_term[c];
      assign out_nxt[c] = ((MODE == MODE_REGISTERED) && (CELL_KIND[c] == CELL_REG)) ?
                          ~reg_nxt[c] : sum[c];
    end
  endgenerate

  assign array_in = {feedback, IN_PINS};

  // ************************************************************
  // Security, preload and signature access
  // ************************************************************
  logic secure_r;
  wire  blocked;
  wire  do_preload;
  wire  do_verify;
  wire  any_req;

  assign blocked    = secure_r;
  assign do_preload = PROG_REQ.preload & ~blocked & ~clearing;
  assign do_verify  = PROG_REQ.verify & ~blocked;
  assign any_req    = PROG_REQ.preload | PROG_REQ.verify | PROG_REQ.sig_read;

  // Register next value: clear, preload, else clocked by common clock
  assign reg_nxt = clearing   ? CELL_RST :
                   do_preload ? PROG_REQ.preload_data :
                   (CLK_EN && MODE == MODE_REGISTERED) ? sum : cell_reg_r;

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      cell_reg_r <= CELL_RST;
      keep_r     <= '0;
      IO_OUT     <= '1;
      IO_OE      <= '0;
      secure_r   <= SECURE_RST;
      SECURED    <= SECURE_RST;
      READY      <= 1'b0;
      PROG_RSP   <= '0;
    end else begin
      cell_reg_r <= reg_nxt;
      keep_r     <= pin_level;
      IO_OUT     <= out_nxt;
      IO_OE      <= oe_nxt;
      // Takes effect from the next cycle and sticks until the next power-up
      secure_r   <= secure_r | PROG_REQ.secure;
      SECURED    <= secure_r | PROG_REQ.secure;
      READY      <= ~clearing;
      PROG_RSP.ack     <= any_req;
      PROG_RSP.refused <= (PROG_REQ.preload | PROG_REQ.verify) & blocked;
      PROG_RSP.data    <= PROG_REQ.sig_read ? SIGNATURE[PROG_REQ.sig_index*8 +: 8] :
                          do_verify ? PATTERN_WORD : 8'h00;
    end
  end

endmodule : pld_core

// *** verif/pld_core_assertions.sv ***
`timescale 1ns/1ps
module pld_core_assertions
  import pld_pkg::*;
(
  input wire logic                       CLOCK,
  input wire logic                       RESET,
  input wire logic                       OE_N,
  input wire logic [NUM_CELLS-1:0]       IO_OUT,
  input wire logic [NUM_CELLS-1:0]       IO_OE,
  input wire mode_t                      MODE,
  input wire cell_kind_t [NUM_CELLS-1:0] CELL_KIND,
  input wire logic [SIG_BITS-1:0]        SIGNATURE,
  input wire prog_req_t                  PROG_REQ,
  input wire prog_rsp_t                  PROG_RSP,
  input wire logic                       SECURED,
  input wire logic                       READY
);
  logic [NUM_CELLS-1:0] in_cell;
  logic [NUM_CELLS-1:0] reg_cell;
  for (genvar g = 0; g < NUM_CELLS; g++) begin : g_kind
    assign in_cell[g]  = CELL_KIND[g] == CELL_IN;
    assign reg_cell[g] = CELL_KIND[g] == CELL_REG;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  AST_CLR:
    assert property ($fell(RESET) |-> IO_OUT == 8'hff && !READY) else $error("outputs not high");
  AST_RDY:
    assert property ($fell(RESET) |-> !READY [*8] ##[2:4] READY) else $error("clear length");
  AST_SIG:
    assert property (PROG_REQ.sig_read |=> PROG_RSP.ack && !PROG_RSP.refused &&
      PROG_RSP.data == SIGNATURE[8*$past(PROG_REQ.sig_index) +: 8]) else $error("signature");
  AST_PRE:
    assert property (READY && !SECURED && PROG_REQ.preload |=> PROG_RSP.ack && !PROG_RSP.refused)
      else $error("preload not taken");
  AST_PREREF:
    assert property (SECURED && PROG_REQ.preload |=> PROG_RSP.refused) else $error("preload open");
  AST_VERREF:
    assert property (SECURED && PROG_REQ.verify && !PROG_REQ.sig_read |=> PROG_RSP.refused &&
      PROG_RSP.data == 8'h00) else $error("verify open");
  AST_INOFF:
    assert property ((IO_OE & in_cell) == 8'h00) else $error("input cell drives");
  AST_REGOE:
    assert property (READY && MODE == MODE_REGISTERED |=> (IO_OE & reg_cell) ==
      ($past(OE_N) ? 8'h00 : reg_cell)) else $error("enable pin ignored");
endmodule : pld_core_assertions
bind pld_core pld_core_assertions u_chk (.CLOCK(CLOCK), .RESET(RESET), .OE_N(OE_N),
  .IO_OUT(IO_OUT), .IO_OE(IO_OE), .MODE(MODE), .CELL_KIND(CELL_KIND), .SIGNATURE(SIGNATURE),
  .PROG_REQ(PROG_REQ), .PROG_RSP(PROG_RSP), .SECURED(SECURED), .READY(READY));

// *** verif/pld_sys_model.sv ***
`timescale 1ns/1ps
module pld_sys_model
  import pld_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  ready,
  input  wire logic                  tick,
  input  wire logic [NUM_INPUTS-1:0] pins,
  input  wire logic [NUM_CELLS-1:0]  drive,
  output logic                       clk_en,
  output logic [NUM_INPUTS-1:0]      in_pins,
  output logic [NUM_CELLS-1:0]       io_in,
  output logic [NUM_CELLS-1:0]       ext_drive
);
  initial {clk_en, in_pins, io_in, ext_drive} = '0;
  // Clock pin stays low through clear; fires only for inputs held a full cycle
  always @(posedge clock) begin
    clk_en    <= tick && ready && pins == in_pins;
    in_pins   <= pins;
    ext_drive <= drive;
    io_in     <= (drive & pins) | (~drive & ~io_in);
  end
endmodule : pld_sys_model

// *** verif/pld_core_test.sv ***
`timescale 1ns/1ps
module pld_core_test
  import pld_pkg::*;
;
  logic                  CLOCK = 1'b0, RESET = 1'b1, OE_N = 1'b1, tick = 1'b0, kept = 1'b0;
  logic                  CLK_EN, SECURED, READY;
  logic [7:0]            pins = 8'h00, drive = 8'h00;
  logic [7:0]            IN_PINS, IO_IN, IO_EXT_DRIVE, IO_OUT, IO_OE, d, pat;
  logic [63:0]           sig;
  cell_kind_t [7:0]      kind;
  logic [7:0][7:0][31:0] tsel = '0;
  logic [7:0][7:0]       tused = '0;
  prog_req_t             rq = '0;
  prog_rsp_t             rsp;
  mode_t                 mode = MODE_REGISTERED;
  int                    seed = 32'hcf43, n_fail = 0, total_checks = 0, i, k;
  pld_core dut (.CLOCK(CLOCK), .RESET(RESET), .CLK_EN(CLK_EN), .OE_N(OE_N), .IN_PINS(IN_PINS),
    .IO_IN(IO_IN), .IO_EXT_DRIVE(IO_EXT_DRIVE), .IO_OUT(IO_OUT), .IO_OE(IO_OE),
    .MODE(mode), .CELL_KIND(kind), .TERM_SEL(tsel), .TERM_USED(tused),
    .SIGNATURE(sig), .PATTERN_WORD(pat), .PROG_REQ(rq), .PROG_RSP(rsp), .SECURED(SECURED),
    .READY(READY));
  pld_sys_model sys (.clock(CLOCK), .ready(READY), .tick(tick), .pins(pins), .drive(drive),
    .clk_en(CLK_EN), .in_pins(IN_PINS), .io_in(IO_IN), .ext_drive(IO_EXT_DRIVE));
  function automatic logic [7:0] reg_out(logic [7:0] r);
    return ~r & 8'h3f;
  endfunction : reg_out
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic send(prog_req_t r);
    @(posedge CLOCK) rq <= r;
    @(posedge CLOCK) rq <= '0;
    #1;
  endtask : send
  task automatic sigs;
    for (int j = 0; j < 8; j++) begin
      send('{sig_read: 1'b1, sig_index: 3'(j), default: '0});
      chk("sig", rsp.data, sig[8*j +: 8]);
    end
  endtask : sigs
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial forever #50 CLOCK = ~CLOCK;
  initial begin
    #300000;
    n_fail++;
    conclude();
  end
  initial begin
    kind = '{default: CELL_REG};
    kind[7] = CELL_IN;
    kind[6] = CELL_BIDI;
    tsel[0][1][0] = 1'b1;
    tused[0] = 8'h02;
    // Input cell 7 shows the level seen at pin 6
    tsel[7][1][14] = 1'b1;
    tused[7] = 8'h02;
    sig = {$random(seed), $random(seed)};
    pat = 8'($random(seed));
    repeat (6) @(posedge CLOCK);
    RESET <= 1'b0;
    for (k = 0; k < 20 && READY !== 1'b1; k++) @(posedge CLOCK) #1;
    chk("clr_len", k, 11);
    chk("out_clr", IO_OUT, 8'h3f);
    for (i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      send('{preload: 1'b1, preload_data: d, default: '0});
      chk("pre", {rsp.ack, IO_OUT & 8'h3f}, {1'b1, reg_out(d)});
    end
    for (i = 0; i < 4; i++) begin
      @(posedge CLOCK) pins <= 8'($random(seed)) | ((i == 0) ? 8'h40 : 8'h00);
      drive <= (i == 0) ? 8'h40 : (i == 1) ? 8'h00 : 8'($random(seed));
      repeat (2) @(posedge CLOCK);
      tick <= 1'b1;
      @(posedge CLOCK) tick <= 1'b0;
      @(posedge CLOCK) #1;
      chk("clk_out", IO_OUT & 8'h3f, reg_out({7'h00, pins[0]}));
      kept = drive[6] ? pins[6] : kept;
      chk("keeper", IO_OUT[7], kept);
    end
    @(posedge CLOCK) OE_N <= 1'b0;
    @(posedge CLOCK) #1;
    chk("oe", IO_OE, 8'h3f);
    sigs();
    send('{verify: 1'b1, default: '0});
    chk("ver", rsp.data, pat);
    send('{secure: 1'b1, default: '0});
    chk("sec", SECURED, 1'b1);
    d = IO_OUT;
    send('{preload: 1'b1, preload_data: ~d, default: '0});
    chk("pre_ref", {rsp.refused, IO_OUT & 8'h3f}, {1'b1, d & 8'h3f});
    send('{verify: 1'b1, default: '0});
    chk("ver_ref", {rsp.refused, rsp.data}, 9'h100);
    sigs();
    // Complex mode: term 0 enables cell 0 and stays out of its sum
    for (i = 0; i < 2; i++) begin
      @(posedge CLOCK) pins <= (i == 0) ? 8'h02 : 8'h01;
      mode <= MODE_COMPLEX;
      tsel[0][0][1] <= 1'b1;
      tused[0] <= 8'h03;
      repeat (2) @(posedge CLOCK) #1;
      chk("complex", {IO_OE[0], IO_OUT[0]}, (i == 0) ? 2'b10 : 2'b01);
    end
    // Simple mode: all eight terms feed the sum, only the input cell is off
    @(posedge CLOCK) mode <= MODE_SIMPLE;
    pins <= 8'h02;
    repeat (2) @(posedge CLOCK) #1;
    chk("simple", {IO_OE, IO_OUT[0]}, {8'h7f, 1'b1});
    @(posedge CLOCK) RESET <= 1'b1;
    @(posedge CLOCK) RESET <= 1'b0;
    #1 chk("rst", {SECURED, IO_OUT}, 9'h0ff);
    for (k = 0; k < 20 && READY !== 1'b1; k++) @(posedge CLOCK) #1;
    chk("clr_len2", k, 11);
    conclude();
  end
endmodule : pld_core_test
